//--- ops_pkg.sv
package ops_pkg;

  // Register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] OPS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] OPS_ADDR_START = 8'h04;
  localparam logic [7:0] OPS_ADDR_COLUMN = 8'h08;
  localparam logic [7:0] OPS_ADDR_CONTRAST = 8'h0C;
  localparam logic [7:0] OPS_ADDR_MUX = 8'h10;
  localparam logic [7:0] OPS_ADDR_STATUS = 8'h14;
  localparam logic [7:0] OPS_ADDR_GEOM = 8'h18;

  // Control register field positions
  localparam int OPS_CTRL_ON_BIT = 0;
  localparam int OPS_CTRL_ENTIRE_BIT = 1;
  localparam int OPS_CTRL_INVERSE_BIT = 2;
  localparam int OPS_CTRL_SEGREMAP_BIT = 3;
  localparam int OPS_CTRL_COMREV_BIT = 4;

  // Status and geometry field positions
  localparam int OPS_STAT_RESET_BIT = 0;
  localparam int OPS_STAT_CMD_LSB = 8;
  localparam int OPS_GEOM_ROWS_LSB = 8;

  // Field widths
  localparam int OPS_START_W = 6;
  localparam int OPS_MUX_W = 6;
  localparam int OPS_CONTRAST_W = 8;
  localparam int OPS_BYTE_W = 8;

  // Documented panel geometry
  localparam int OPS_COLS = 128;
  localparam int OPS_ROWS = 64;

  // Reset values
  localparam logic [OPS_START_W-1:0] OPS_START_RST = 6'h00;
  localparam logic [OPS_CONTRAST_W-1:0] OPS_CONTRAST_RST = 8'h7F;
  localparam logic [OPS_MUX_W-1:0] OPS_MUX_RST = 6'h3F;
  localparam logic [OPS_BYTE_W-1:0] OPS_CMD_RST = 8'h00;

  // Command bytes decoded from the serial port
  localparam logic [OPS_BYTE_W-1:0] OPS_CMD_DISPLAY_OFF = 8'hAE;
  localparam logic [OPS_BYTE_W-1:0] OPS_CMD_DISPLAY_ON = 8'hAF;
  localparam logic [OPS_BYTE_W-1:0] OPS_CMD_FOLLOW_RAM = 8'hA4;
  localparam logic [OPS_BYTE_W-1:0] OPS_CMD_ENTIRE_ON = 8'hA5;
  localparam logic [OPS_BYTE_W-1:0] OPS_CMD_NORMAL = 8'hA6;
  localparam logic [OPS_BYTE_W-1:0] OPS_CMD_INVERSE = 8'hA7;

  // Display configuration carried as one unit
  typedef struct packed {
    logic display_on;
    logic entire_on;
    logic inverse;
    logic seg_remap;
    logic com_reverse;
    logic [OPS_START_W-1:0] start_line;
    logic [OPS_CONTRAST_W-1:0] contrast;
    logic [OPS_MUX_W-1:0] mux;
  } ops_disp_cfg_s;

  localparam ops_disp_cfg_s OPS_CFG_RST = '{
    display_on: 1'b0,
    entire_on: 1'b0,
    inverse: 1'b0,
    seg_remap: 1'b0,
    com_reverse: 1'b0,
    start_line: OPS_START_RST,
    contrast: OPS_CONTRAST_RST,
    mux: OPS_MUX_RST
  };

endpackage

//--- ops_serial_shift.sv
module ops_serial_shift
  import ops_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  // Serial pins
  input wire logic sclk,
  input wire logic sdin,
  input wire logic cs_n,
  input wire logic dc,
  // Received byte
  output logic byte_valid,
  output logic [OPS_BYTE_W-1:0] byte_data,
  output logic byte_dc
);

  logic sclk_prev;
  logic [OPS_BYTE_W-1:0] shift;
  logic [3:0] bit_cnt;
  logic sclk_rise;

  // Pins are synchronous to clk_sys, so a plain edge detect suffices
  assign sclk_rise = sclk & ~sclk_prev & ~cs_n;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclk_prev <= 1'b0;
    end else if (ce) begin
      sclk_prev <= sclk;
    end
  end

  // Shift in MSB first; chip deselect also drops a partial byte
  // RL4: clear partial bits
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift <= '0;
      bit_cnt <= '0;
      byte_valid <= 1'b0;
      byte_data <= '0;
      byte_dc <= 1'b0;
    end else if (ce) begin
      byte_valid <= 1'b0;
      if (clr || cs_n) begin
        shift <= '0;
        bit_cnt <= '0;
      end else if (sclk_rise) begin
        shift <= {shift[OPS_BYTE_W-2:0], sdin};
        if (bit_cnt == 4'(OPS_BYTE_W - 1)) begin
          bit_cnt <= '0;
          byte_valid <= 1'b1;
          byte_data <= {shift[OPS_BYTE_W-2:0], sdin};
          byte_dc <= dc;
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_clr_empties;
    (ce && clr) |=> (bit_cnt == 4'h0 && shift == '0 && !byte_valid);
  endproperty
  a_clr_empties: assert property (p_clr_empties) else $error("shift not cleared"); // RL4

endmodule // ops_serial_shift

//--- ops_column_counter.sv
module ops_column_counter
  import ops_pkg::*;
#(
  parameter int COLS = OPS_COLS,
  parameter int COL_W = $clog2(COLS)
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  // Load and advance
  input wire logic load,
  input wire logic [COL_W-1:0] load_val,
  input wire logic inc,
  // Current column
  output logic [COL_W-1:0] column
);

  localparam logic [COL_W-1:0] LAST = COL_W'(COLS - 1);

  initial begin
    if (COLS < 2 || COLS > (1 << COL_W)) begin
      $error("COLS does not fit COL_W");
    end
  end

  // Pin reset beats a load, a load beats an advance; wrap after the last column
  // RL6: column to zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      column <= '0;
    end else if (ce) begin
      if (clr) begin
        column <= '0;
      end else if (load) begin
        column <= (load_val > LAST) ? LAST : load_val;
      end else if (inc) begin
        column <= (column == LAST) ? '0 : column + 1'b1;
      end
    end
  end

endmodule // ops_column_counter

//--- ops_sequencer_core.sv
// What this block and the host model do
// RL1: Held module reset turns display off and selects RAM-following normal mode.
// RL2: Reset selects the 128 by 64 pixel configuration.
// RL3: Reset restores normal segment mapping and normal common scan direction.
// RL4: Reset clears partial bits in the serial shift register.
// RL5: Reset sets display start line to memory line zero.
// RL6: Reset loads the column address counter with zero.
// RL7: Reset loads contrast with 7Fh.
// RL8: Host sends display off, init, clear, then enables panel supply.
// RL9: Host waits 100ms after panel supply before display on.
// RL10: Host powers down display, panel supply, waits 100ms, then logic supply.
// RL11: Host resets the display if noise corrupts the picture. Host model has no reset pin; the testbench drives it.
// RL12: Host times each 100ms wait from its clock and flags completion.
module ops_sequencer_core
  import ops_pkg::*;
#(
  parameter int COLS = OPS_COLS,
  parameter int ROWS = OPS_ROWS,
  parameter int COL_W = $clog2(COLS)
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Module reset pin
  input wire logic module_reset_input_n,
  // Serial command port
  input wire logic sclk,
  input wire logic sdin,
  input wire logic cs_n,
  input wire logic dc,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Display state
  output ops_disp_cfg_s disp_cfg,
  output logic [COL_W-1:0] column,
  output logic pixel_valid,
  output logic [OPS_BYTE_W-1:0] pixel_byte,
  output logic in_reset
);

  initial begin
    if (COLS > 255 || ROWS > 64 || ROWS < 2) begin
      $error("Geometry outside what the registers can hold");
    end
  end

  logic pin_reset;
  logic wb_req;
  logic wb_wr;
  logic lane0;
  logic wr_ctrl;
  logic wr_start;
  logic wr_column;
  logic wr_contrast;
  logic wr_mux;
  logic byte_valid;
  logic byte_dc;
  logic [OPS_BYTE_W-1:0] byte_data;
  logic cmd_valid;
  logic data_valid;
  logic [OPS_BYTE_W-1:0] last_cmd;
  logic [31:0] next_rdata;

  // Pin reset acts as a level on each enabled edge, so it holds state while low
  assign pin_reset = ~module_reset_input_n;

  // New request only while ack is low, so every access gets exactly one ack
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;
  assign lane0 = wb_sel_i[0];
  assign wr_ctrl = wb_wr & lane0 & (wb_adr_i == OPS_ADDR_CTRL);
  assign wr_start = wb_wr & lane0 & (wb_adr_i == OPS_ADDR_START);
  assign wr_column = wb_wr & lane0 & (wb_adr_i == OPS_ADDR_COLUMN);
  assign wr_contrast = wb_wr & lane0 & (wb_adr_i == OPS_ADDR_CONTRAST);
  assign wr_mux = wb_wr & lane0 & (wb_adr_i == OPS_ADDR_MUX);

  // Serial bytes split into commands and display data by the dc pin
  assign cmd_valid = byte_valid & ~byte_dc;
  assign data_valid = byte_valid & byte_dc;

  // Serial receiver
  ops_serial_shift u_shift (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .clr(pin_reset),
    .sclk(sclk),
    .sdin(sdin),
    .cs_n(cs_n),
    .dc(dc),
    .byte_valid(byte_valid),
    .byte_data(byte_data),
    .byte_dc(byte_dc)
  );

  // Column address, advanced by each display data byte
  ops_column_counter #(
    .COLS(COLS),
    .COL_W(COL_W)
  ) u_column (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .clr(pin_reset),
    .load(wr_column),
    .load_val(wb_dat_i[COL_W-1:0]),
    .inc(data_valid),
    .column(column)
  );

  // Display configuration in one process, so the struct has a single driver;
  // mode flags: pin reset first, then software, then serial commands
  // RL1: off and normal mode
  // RL2: full 64-row geometry
  // RL3: normal mapping restored
  // RL5: start line zero
  // RL7: contrast to 7Fh
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      disp_cfg.display_on <= OPS_CFG_RST.display_on;
      disp_cfg.entire_on <= OPS_CFG_RST.entire_on;
      disp_cfg.inverse <= OPS_CFG_RST.inverse;
      disp_cfg.seg_remap <= OPS_CFG_RST.seg_remap;
      disp_cfg.com_reverse <= OPS_CFG_RST.com_reverse;
      disp_cfg.start_line <= OPS_CFG_RST.start_line;
      disp_cfg.contrast <= OPS_CFG_RST.contrast;
      disp_cfg.mux <= OPS_MUX_W'(ROWS - 1);
    end else if (ce) begin
      if (pin_reset) begin
        disp_cfg.display_on <= OPS_CFG_RST.display_on;
        disp_cfg.entire_on <= OPS_CFG_RST.entire_on;
        disp_cfg.inverse <= OPS_CFG_RST.inverse;
        disp_cfg.seg_remap <= OPS_CFG_RST.seg_remap;
        disp_cfg.com_reverse <= OPS_CFG_RST.com_reverse;
        disp_cfg.start_line <= OPS_CFG_RST.start_line;
        disp_cfg.contrast <= OPS_CFG_RST.contrast;
        disp_cfg.mux <= OPS_MUX_W'(ROWS - 1);
      end else begin
        if (wr_ctrl) begin
          disp_cfg.display_on <= wb_dat_i[OPS_CTRL_ON_BIT];
          disp_cfg.entire_on <= wb_dat_i[OPS_CTRL_ENTIRE_BIT];
          disp_cfg.inverse <= wb_dat_i[OPS_CTRL_INVERSE_BIT];
          disp_cfg.seg_remap <= wb_dat_i[OPS_CTRL_SEGREMAP_BIT];
          disp_cfg.com_reverse <= wb_dat_i[OPS_CTRL_COMREV_BIT];
        end else if (cmd_valid) begin
          case (byte_data)
            OPS_CMD_DISPLAY_OFF: disp_cfg.display_on <= 1'b0;
            OPS_CMD_DISPLAY_ON: disp_cfg.display_on <= 1'b1;
            OPS_CMD_FOLLOW_RAM: disp_cfg.entire_on <= 1'b0;
            OPS_CMD_ENTIRE_ON: disp_cfg.entire_on <= 1'b1;
            OPS_CMD_NORMAL: disp_cfg.inverse <= 1'b0;
            OPS_CMD_INVERSE: disp_cfg.inverse <= 1'b1;
            default: disp_cfg.display_on <= disp_cfg.display_on;
          endcase
        end
        if (wr_start) begin
          disp_cfg.start_line <= wb_dat_i[OPS_START_W-1:0];
        end
        if (wr_contrast) begin
          disp_cfg.contrast <= wb_dat_i[OPS_CONTRAST_W-1:0];
        end
        if (wr_mux) begin
          disp_cfg.mux <= wb_dat_i[OPS_MUX_W-1:0];
        end
      end
    end
  end

  // Last command byte and reset-held flag, visible to software
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_cmd <= OPS_CMD_RST;
      in_reset <= 1'b0;
    end else if (ce) begin
      in_reset <= pin_reset;
      if (pin_reset) begin
        last_cmd <= OPS_CMD_RST;
      end else if (cmd_valid) begin
        last_cmd <= byte_data;
      end
    end
  end

  // Data bytes pass out one cycle later, when column already points past the one they land in
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pixel_valid <= 1'b0;
      pixel_byte <= '0;
    end else if (ce) begin
      pixel_valid <= data_valid & ~pin_reset;
      if (data_valid) begin
        pixel_byte <= byte_data;
      end
    end
  end

  // Read mux; unmapped addresses read zero and are still acknowledged
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      OPS_ADDR_CTRL: begin
        next_rdata[OPS_CTRL_ON_BIT] = disp_cfg.display_on;
        next_rdata[OPS_CTRL_ENTIRE_BIT] = disp_cfg.entire_on;
        next_rdata[OPS_CTRL_INVERSE_BIT] = disp_cfg.inverse;
        next_rdata[OPS_CTRL_SEGREMAP_BIT] = disp_cfg.seg_remap;
        next_rdata[OPS_CTRL_COMREV_BIT] = disp_cfg.com_reverse;
      end
      OPS_ADDR_START: next_rdata[OPS_START_W-1:0] = disp_cfg.start_line;
      OPS_ADDR_COLUMN: next_rdata[COL_W-1:0] = column;
      OPS_ADDR_CONTRAST: next_rdata[OPS_CONTRAST_W-1:0] = disp_cfg.contrast;
      OPS_ADDR_MUX: next_rdata[OPS_MUX_W-1:0] = disp_cfg.mux;
      OPS_ADDR_STATUS: begin
        next_rdata[OPS_STAT_RESET_BIT] = in_reset;
        next_rdata[OPS_STAT_CMD_LSB +: OPS_BYTE_W] = last_cmd;
      end
      OPS_ADDR_GEOM: begin
        next_rdata[OPS_BYTE_W-1:0] = OPS_BYTE_W'(COLS);
        next_rdata[OPS_GEOM_ROWS_LSB +: OPS_BYTE_W] = OPS_BYTE_W'(ROWS);
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Bus answer one cycle after the request; ack drops the cycle after
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_pin_reset;
    ce && pin_reset;
  endsequence

  sequence s_bus_req;
    ce && wb_req;
  endsequence

  property p_rst_off;
    s_pin_reset |=> (!disp_cfg.display_on && !disp_cfg.entire_on && !disp_cfg.inverse);
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("display not off in reset"); // RL1

  property p_rst_geom;
    s_pin_reset |=> (disp_cfg.mux == OPS_MUX_W'(ROWS - 1));
  endproperty
  a_rst_geom: assert property (p_rst_geom) else $error("row count wrong in reset"); // RL2

  property p_rst_map;
    s_pin_reset |=> (!disp_cfg.seg_remap && !disp_cfg.com_reverse);
  endproperty
  a_rst_map: assert property (p_rst_map) else $error("mapping not normal in reset"); // RL3

  property p_rst_start;
    s_pin_reset |=> (disp_cfg.start_line == OPS_START_RST);
  endproperty
  a_rst_start: assert property (p_rst_start) else $error("start line not zero"); // RL5

  property p_rst_column;
    s_pin_reset |=> (column == '0);
  endproperty
  a_rst_column: assert property (p_rst_column) else $error("column not zero"); // RL6

  property p_rst_contrast;
    s_pin_reset |=> (disp_cfg.contrast == OPS_CONTRAST_RST);
  endproperty
  a_rst_contrast: assert property (p_rst_contrast) else $error("contrast not 7F"); // RL7

  property p_hold_off;
    (s_pin_reset [*3]) |=> (!disp_cfg.display_on && in_reset && !pixel_valid);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("state leaks in held reset"); // RL1

  property p_ack_once;
    s_bus_req |=> (wb_ack_o ##1 (!wb_ack_o || !ce));
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("bus ack not single"); // bus handshake, not a reset rule

  property p_cmd_on;
    (ce && cmd_valid && !pin_reset && !wr_ctrl && byte_data == OPS_CMD_DISPLAY_ON)
      |=> disp_cfg.display_on;
  endproperty
  a_cmd_on: assert property (p_cmd_on) else $error("display on command lost"); // serial display on command, not a reset rule

endmodule // ops_sequencer_core

//--- ops_host_model.sv
module ops_host_model
  import ops_pkg::*;
#(
  // Stands for the 100 ms settle and discharge waits, scaled down
  parameter int WAIT_CYC = 2000
) (
  // Clock
  input wire logic clk_sys,
  // Serial command pins
  output logic sclk,
  output logic sdin,
  output logic cs_n,
  output logic dc,
  // Supplies and completion
  output logic panel_on,
  output logic logic_on,
  output logic seq_done
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: deselected, serial clock parked low
  initial begin
    sclk = 1'b0;
    sdin = 1'b0;
    cs_n = 1'b1;
    dc = 1'b0;
    panel_on = 1'b0;
    logic_on = 1'b1;
    seq_done = 1'b0;
  end

  // Shift nbits MSB first; keep leaves the port selected mid-byte
  task automatic send(input logic [7:0] b, input logic d, input int nbits, input int slow,
                      input logic keep);
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk_sys);
      cs_n <= 1'b0;
      sclk <= 1'b0;
      sdin <= b[7-i];
      dc <= d;
      repeat (slow) @(posedge clk_sys);
      @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (slow) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    // Released lines must not keep their last value
    if (!keep) begin
      cs_n <= 1'b1;
      sclk <= 1'b0;
      sdin <= ~sdin;
      dc <= ~d;
    end
  endtask

  // display off, init, clear, then panel supply
  task automatic power_up();
    seq_done <= 1'b0;
    send(OPS_CMD_DISPLAY_OFF, 1'b0, 8, 0, 1'b0);
    send(OPS_CMD_FOLLOW_RAM, 1'b0, 8, 0, 1'b0);
    send(OPS_CMD_NORMAL, 1'b0, 8, 0, 1'b0);
    for (int i = 0; i < OPS_COLS; i++) send(8'h00, 1'b1, 8, 0, 1'b0);
    panel_on <= 1'b1;
    repeat (WAIT_CYC) @(posedge clk_sys);
    send(OPS_CMD_DISPLAY_ON, 1'b0, 8, 0, 1'b0);
    seq_done <= 1'b1;
  endtask

  // off, panel down, discharge wait, logic last
  task automatic power_down();
    seq_done <= 1'b0;
    send(OPS_CMD_DISPLAY_OFF, 1'b0, 8, 0, 1'b0);
    panel_on <= 1'b0;
    repeat (WAIT_CYC) @(posedge clk_sys);
    logic_on <= 1'b0;
    seq_done <= 1'b1;
  endtask
endmodule // ops_host_model

//--- tb_oled_power_reset_sequencer.sv
module tb_oled_power_reset_sequencer
  import ops_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic we; logic [7:0] adr; logic [31:0] d;} ops_row_s;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic module_reset_input_n = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  ops_disp_cfg_s disp_cfg;
  logic [6:0] column;
  logic pixel_valid;
  logic [7:0] pixel_byte;
  logic in_reset;
  logic sclk, sdin, cs_n, dc, panel_on, logic_on, seq_done;
  int errors = 0;
  int n_compared = 0;
  int cyc_n = 0;
  int pix_cnt = 0;
  localparam int WAIT_CYC = 2000;
  int panel_cyc = 0;
  logic panel_prev = 1'b0, on_prev = 1'b0, logic_prev = 1'b1;
  logic [7:0] pix_last = 8'h00;
  // Reads carry the expected value in d; writes carry the data
  ops_row_s rows [20] = '{
    '{1'b0, OPS_ADDR_CTRL, 32'h0}, '{1'b0, OPS_ADDR_START, 32'h0},
    '{1'b0, OPS_ADDR_COLUMN, 32'h0}, '{1'b0, OPS_ADDR_CONTRAST, 32'h7F},
    '{1'b0, OPS_ADDR_MUX, 32'h3F}, '{1'b0, OPS_ADDR_STATUS, 32'h0},
    '{1'b0, OPS_ADDR_GEOM, 32'h4080}, '{1'b0, 8'h1C, 32'h0},
    '{1'b1, OPS_ADDR_CONTRAST, 32'h12}, '{1'b0, OPS_ADDR_CONTRAST, 32'h12},
    '{1'b1, OPS_ADDR_START, 32'h3F}, '{1'b0, OPS_ADDR_START, 32'h3F},
    '{1'b1, OPS_ADDR_COLUMN, 32'hFF}, '{1'b0, OPS_ADDR_COLUMN, 32'h7F},
    '{1'b1, OPS_ADDR_GEOM, 32'h0}, '{1'b0, OPS_ADDR_GEOM, 32'h4080},
    '{1'b1, 8'h1C, 32'hFFFFFFFF}, '{1'b0, 8'h1C, 32'h0},
    '{1'b1, OPS_ADDR_CTRL, 32'h1F}, '{1'b0, OPS_ADDR_CTRL, 32'h1F}};
  logic [7:0] cmds [6] = '{OPS_CMD_FOLLOW_RAM, OPS_CMD_NORMAL, OPS_CMD_DISPLAY_OFF,
                           OPS_CMD_DISPLAY_ON, OPS_CMD_ENTIRE_ON, OPS_CMD_INVERSE};
  logic [2:0] mode_exp [6] = '{3'h5, 3'h4, 3'h0, 3'h4, 3'h6, 3'h7};

  always #2 clk_sys = ~clk_sys;

  ops_sequencer_core ops_sequencer_core_inst (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .module_reset_input_n(module_reset_input_n),
    .sclk(sclk), .sdin(sdin), .cs_n(cs_n), .dc(dc),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .disp_cfg(disp_cfg), .column(column), .pixel_valid(pixel_valid),
    .pixel_byte(pixel_byte), .in_reset(in_reset));

  ops_host_model #(.WAIT_CYC(WAIT_CYC)) ops_host_model_inst (
    .clk_sys(clk_sys), .sclk(sclk), .sdin(sdin), .cs_n(cs_n), .dc(dc),
    .panel_on(panel_on), .logic_on(logic_on), .seq_done(seq_done));

  // Count data bytes; the pulse stands one cycle only
  always @(posedge clk_sys) begin
    if (pixel_valid === 1'b1) begin
      pix_cnt++;
      pix_last = pixel_byte;
    end
  end

  // Supply steps watched against the host's waits; a short wait trips these
  always @(posedge clk_sys) begin
    panel_cyc = (panel_on === panel_prev) ? panel_cyc + 1 : 0;
    if (panel_on === 1'b1 && panel_prev === 1'b0) check(disp_cfg.display_on, 32'h0);
    if (disp_cfg.display_on === 1'b1 && !on_prev && panel_on === 1'b1) begin
      check(panel_cyc >= WAIT_CYC, 32'h1);
    end
    if (logic_on === 1'b0 && logic_prev === 1'b1) begin
      check({panel_on, panel_cyc >= WAIT_CYC}, 32'h1);
    end
    panel_prev = panel_on;
    on_prev = disp_cfg.display_on;
    logic_prev = logic_on;
  end

  // Hang guard, well above the few thousand cycles needed
  always @(posedge clk_sys) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      errors++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One classic cycle; waits for ack, never assumes its latency
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] q;
    int n0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      wb_xfer(rows[i].we, rows[i].adr, rows[i].d, q);
      if (!rows[i].we) check(q, rows[i].d);
    end
    // A write without byte lane 0 is acked but changes nothing
    wb_sel_i <= 4'hE;
    wb_xfer(1'b1, OPS_ADDR_START, 32'h0, q);
    wb_sel_i <= 4'hF;
    wb_xfer(1'b0, OPS_ADDR_START, 32'h0, q);
    check(q, 32'h3F);
    $display("test register table done");
    foreach (cmds[i]) begin
      ops_host_model_inst.send(cmds[i], 1'b0, 8, i % 2, 1'b0);
      repeat (3) @(posedge clk_sys);
      check({disp_cfg.display_on, disp_cfg.entire_on, disp_cfg.inverse}, mode_exp[i]);
    end
    wb_xfer(1'b0, OPS_ADDR_STATUS, 32'h0, q);
    check(q, 32'hA700);
    $display("test serial commands done");
    // Slow clocking; column wraps from 127 to 0
    n0 = pix_cnt;
    ops_host_model_inst.send(8'h5A, 1'b1, 8, 2, 1'b0);
    repeat (3) @(posedge clk_sys);
    check(pix_cnt - n0, 32'h1);
    check(pix_last, 8'h5A);
    check(column, 32'h0);
    $display("test data byte done");
    n0 = pix_cnt;
    ops_host_model_inst.power_up();
    repeat (3) @(posedge clk_sys);
    check(pix_cnt - n0, OPS_COLS);
    check(column, 32'h0);
    check({disp_cfg.display_on, panel_on, seq_done}, 3'h7);
    ops_host_model_inst.power_down();
    @(posedge clk_sys);
    check({disp_cfg.display_on, panel_on, logic_on, seq_done}, 4'h1);
    $display("test power sequences done");
    // recover by pulsing the module reset mid-byte
    wb_xfer(1'b1, OPS_ADDR_CTRL, 32'h1F, q);
    wb_xfer(1'b1, OPS_ADDR_COLUMN, 32'h5, q);
    ops_host_model_inst.send(8'hF0, 1'b1, 4, 0, 1'b1);
    module_reset_input_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(in_reset, 32'h1);
    wb_xfer(1'b1, OPS_ADDR_CONTRAST, 32'h12, q);
    wb_xfer(1'b0, OPS_ADDR_STATUS, 32'h0, q);
    check(q, 32'h1);
    check(disp_cfg, OPS_CFG_RST);
    check(column, 32'h0);
    module_reset_input_n <= 1'b1;
    @(posedge clk_sys);
    ops_host_model_inst.send(8'h3C, 1'b1, 8, 0, 1'b0);
    repeat (3) @(posedge clk_sys);
    check(pix_last, 8'h3C);
    check(column, 32'h1);
    $display("test pin reset done");
    // Enable low freezes the receiver and the column
    ce <= 1'b0;
    n0 = pix_cnt;
    ops_host_model_inst.send(8'h81, 1'b1, 8, 0, 1'b0);
    repeat (3) @(posedge clk_sys);
    check(pix_cnt - n0, 32'h0);
    check(column, 32'h1);
    ce <= 1'b1;
    $display("test clock enable done");
    stop_test();
  end
endmodule // tb_oled_power_reset_sequencer
